/* File: epc_arb.sv */
// lowest-key picker over all exception positions
`timescale 1ns/1ns
module epc_arb #(
    parameter int N = 48,
    parameter int W = 4,
    parameter int IW = 6
) (
    input wire logic [N-1:0] vld,
    input wire logic [N*W-1:0] key,
    output logic any,
    output logic [IW-1:0] idx
);

    logic [W-1:0] best;

    // strict compare keeps the lower position on equal keys
    always_comb
    begin
        any = 1'b0;
        idx = '0;
        best = '1;
        for (int i = 0; i < N; i++)
        begin
            if (vld[i] && (!any || key[i*W +: W] < best))
            begin
                any = 1'b1;
                idx = IW'(i);
                best = key[i*W +: W];
            end
        end
    end

endmodule

/* File: epc_core_model.sv */
// core model: ends each handler after a chosen run of quiet handler cycles
`timescale 1ns/1ns
module epc_core_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hmode,
    input wire logic busy,
    input wire logic [7:0] dly,
    output logic exc_ret
);
    logic [7:0] cnt_q;
    // return pulse after dly+1 quiet cycles; a push, pop or fetch cycle restarts the count
    always_ff @(posedge clk)
    begin
        cnt_q <= (!rst_b || !hmode || busy || exc_ret) ? 8'h00 : cnt_q + 8'h01;
        exc_ret <= rst_b && hmode && !busy && !exc_ret && cnt_q == dly;
    end
endmodule

/* File: epc_pkg.sv */
// shared constants and types of the exception priority controller
package epc_pkg;

    // -------------------------------------------------------------
    // positions and ranks
    // -------------------------------------------------------------
    localparam int NPOS = 48;
    localparam int NIRQ = 32;
    // gpio a-c, uart_port_zero, sync_serial_port, watchdog, timer halves, comparators, sysctl, flash
    localparam logic [31:0] IRQ_IMPL = 32'h367C00A7;
    // system positions 2-6, 11, 12, 14, 15 plus the implemented peripheral lines
    localparam logic [47:0] POS_IMPL = {IRQ_IMPL, 16'hD87C};
    // positions of the seven settable system handlers, index 6 first
    localparam logic [6:0][5:0] SYS_POS = {6'h0F, 6'h0E, 6'h0C, 6'h0B, 6'h06, 6'h05, 6'h04};
    localparam logic [5:0] POS_NMI = 6'h02;
    localparam logic [5:0] POS_HARD = 6'h03;
    localparam logic [5:0] POS_MEM = 6'h04;
    localparam logic [5:0] POS_BUS = 6'h05;
    localparam logic [5:0] POS_USAGE = 6'h06;
    localparam logic [5:0] POS_SVC = 6'h0B;
    localparam logic [5:0] POS_DBG = 6'h0C;
    localparam logic [5:0] POS_PSV = 6'h0E;
    localparam logic [5:0] POS_TICK = 6'h0F;
    localparam logic [5:0] POS_IRQ0 = 6'h10;
    localparam logic [3:0] RANK_NMI = 4'h1;
    localparam logic [3:0] RANK_HARD = 4'h2;
    localparam logic [3:0] RANK_OFS = 4'h3;
    localparam logic [3:0] RANK_BASE = 4'hF;

    // -------------------------------------------------------------
    // register map and fields
    // -------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_IRQ_EN = 8'h04;
    localparam logic [7:0] REG_IRQ_PEND = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_SYS_PRI = 8'h10;
    localparam logic [7:0] REG_IRQ_PRI0 = 8'h14;
    localparam logic [7:0] REG_IRQ_PRI3 = 8'h20;
    localparam int CTRL_BUS_EN = 3;
    localparam int CTRL_DBG_EN = 4;
    localparam int CTRL_NMI_SET = 8;
    localparam int CTRL_PSV_SET = 9;
    localparam int CTRL_PSV_CLR = 10;

    // -------------------------------------------------------------
    // sequencing counts and vector entries
    // -------------------------------------------------------------
    localparam logic [3:0] STACK_CYC = 4'h8;
    localparam logic [3:0] CHAIN_CYC = 4'h2;
    localparam logic [7:0] VEC_SP = 8'h00;
    localparam logic [7:0] VEC_RST = 8'h04;

    typedef enum logic [6:0] {
        ST_LOAD_SP = 7'h01,
        ST_FETCH_RST = 7'h02,
        ST_THREAD = 7'h04,
        ST_STACK = 7'h08,
        ST_HANDLER = 7'h10,
        ST_UNSTACK = 7'h20,
        ST_CHAIN = 7'h40
    } epc_st_type;

    typedef struct packed {
        logic [5:0] pos;
        logic [3:0] rank;
    } epc_stk_type;

    typedef struct packed {
        epc_st_type st;
        logic [3:0] cnt;
        logic [3:0] dep;
        epc_stk_type [15:0] stk;
        logic [5:0] act_pos;
        logic [3:0] act_rank;
        logic [47:0] pend;
        logic [31:0] en;
        logic [1:0] grp;
        logic bus_en;
        logic dbg_en;
        logic [6:0][2:0] sys_pri;
        logic [31:0][2:0] irq_pri;
        logic [31:0] irq_s1;
        logic [31:0] irq_s2;
        logic imp_s1;
        logic imp_s2;
        logic imp_s3;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        logic [7:0] vec_addr;
        logic vec_fetch;
        logic push;
        logic pop;
        logic load_sp;
        logic chain;
        logic hmode;
    } epc_state_type;

    localparam epc_state_type STATE_RST = '{st: ST_LOAD_SP, act_rank: RANK_BASE, hreadyout: 1'b1,
                                            load_sp: 1'b1, default: '0};

endpackage

/* File: epc_top.sv */
// exception priority controller: ranking, pending state, entry, return and tail-chaining
`timescale 1ns/1ns
module epc_top (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [31:0] IRQ_IN,
    input wire logic MEM_FAULT,
    input wire logic BUS_FAULT_PRECISE,
    input wire logic BUS_FAULT_IMPRECISE,
    input wire logic USAGE_FAULT,
    input wire logic SVC_CALL,
    input wire logic DEBUG_MON_REQ,
    input wire logic TICK_EXPIRE,
    input wire logic EXC_RETURN,
    output logic LOAD_SP,
    output logic VEC_FETCH,
    output logic [7:0] VEC_ADDR,
    output logic STACK_PUSH,
    output logic STACK_POP,
    output logic TAIL_CHAIN,
    output logic HANDLER_MODE,
    output logic [5:0] ACTIVE_NUM
);

    epc_pkg::epc_state_type s_q;
    epc_pkg::epc_state_type s_d;
    logic [47:0][3:0] full;
    logic [47:0][3:0] pre;
    logic [47:0] vld;
    logic [47:0] set;
    logic [47:0] clr;
    logic any;
    logic [5:0] w_idx;
    logic [3:0] w_pre;
    logic take;
    logic acc;
    logic nmi_wr;
    logic [31:0] rd;
    logic [7:0] off;
    logic [1:0] m;
    epc_pkg::epc_stk_type top;

    // -------------------------------------------------------------
    // ranking
    // -------------------------------------------------------------

    // full rank picks the winner, pre-emption rank decides preemption
    always_comb
    begin
        full = '0;
        pre = '0;
        full[epc_pkg::POS_NMI] = epc_pkg::RANK_NMI;
        pre[epc_pkg::POS_NMI] = epc_pkg::RANK_NMI;
        full[epc_pkg::POS_HARD] = epc_pkg::RANK_HARD;
        pre[epc_pkg::POS_HARD] = epc_pkg::RANK_HARD;
        for (int k = 0; k < 7; k++)
        begin
            full[epc_pkg::SYS_POS[k]] = epc_pkg::RANK_OFS + {1'b0, s_q.sys_pri[k]};
            pre[epc_pkg::SYS_POS[k]] = epc_pkg::RANK_OFS + {1'b0, s_q.sys_pri[k] >> s_q.grp};
        end
        for (int i = 0; i < epc_pkg::NIRQ; i++)
        begin
            full[16 + i] = epc_pkg::RANK_OFS + {1'b0, s_q.irq_pri[i]};
            pre[16 + i] = epc_pkg::RANK_OFS + {1'b0, s_q.irq_pri[i] >> s_q.grp};
        end
        // reserved positions never compete; peripheral lines need their enable
        vld = s_q.pend & epc_pkg::POS_IMPL & {s_q.en, 16'hFFFF};
    end

    epc_arb #(
        .N(epc_pkg::NPOS),
        .W(4),
        .IW(6)
    ) u_arb (
        .vld(vld),
        .key(full),
        .any(any),
        .idx(w_idx)
    );

    assign w_pre = pre[w_idx];
    assign top = s_q.stk[s_q.dep - 4'h1];
    // preempt only when strictly more urgent than the running level
    assign take = any && (w_pre < s_q.act_rank) && (s_q.st == epc_pkg::ST_THREAD ||
                  (s_q.st == epc_pkg::ST_HANDLER && !EXC_RETURN));
    assign acc = HSEL && HREADY && HTRANS[1];
    assign nmi_wr = s_q.wr_pend && s_q.wr_addr == epc_pkg::REG_CTRL && HWDATA[epc_pkg::CTRL_NMI_SET];
    assign off = s_q.wr_addr - epc_pkg::REG_IRQ_PRI0;
    assign m = off[3:2];

    // -------------------------------------------------------------
    // register read mux
    // -------------------------------------------------------------

    // read data is selected in the address phase and registered
    always_comb
    begin
        rd = '0;
        case ({HADDR[7:2], 2'b00})
            epc_pkg::REG_CTRL:
            begin
                rd[1:0] = s_q.grp;
                rd[epc_pkg::CTRL_BUS_EN] = s_q.bus_en;
                rd[epc_pkg::CTRL_DBG_EN] = s_q.dbg_en;
                rd[epc_pkg::CTRL_NMI_SET] = s_q.pend[epc_pkg::POS_NMI];
                rd[epc_pkg::CTRL_PSV_SET] = s_q.pend[epc_pkg::POS_PSV];
            end
            epc_pkg::REG_IRQ_EN: rd = s_q.en;
            epc_pkg::REG_IRQ_PEND: rd = s_q.pend[47:16];
            epc_pkg::REG_STATUS: rd[14:0] = {s_q.dep, s_q.hmode, s_q.act_rank, s_q.act_pos};
            epc_pkg::REG_SYS_PRI:
            begin
                for (int k = 0; k < 7; k++)
                    rd[3*k +: 3] = s_q.sys_pri[k];
            end
            8'h14, 8'h18, 8'h1C, epc_pkg::REG_IRQ_PRI3:
            begin
                for (int j = 0; j < 8; j++)
                    rd[4*j +: 3] = s_q.irq_pri[8*(HADDR[5:2] - 4'h5) + j];
            end
            default: rd = '0;
        endcase
    end

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------

    always_comb
    begin
        s_d = s_q;
        set = '0;
        clr = '0;
        s_d.chain = 1'b0;
        s_d.hreadyout = 1'b1;
        s_d.hresp = 1'b0;
        // two-flop synchronisers for lines from outside the core
        s_d.irq_s1 = IRQ_IN;
        s_d.irq_s2 = s_q.irq_s1;
        s_d.imp_s1 = BUS_FAULT_IMPRECISE;
        s_d.imp_s2 = s_q.imp_s1;
        s_d.imp_s3 = s_q.imp_s2;

        // bus address phase, zero wait states
        s_d.wr_pend = acc && HWRITE;
        s_d.wr_addr = {HADDR[7:2], 2'b00};
        s_d.hrdata = (acc && !HWRITE) ? rd : '0;

        // bus write data phase
        if (s_q.wr_pend)
        begin
            case (s_q.wr_addr)
                epc_pkg::REG_CTRL:
                begin
                    s_d.grp = HWDATA[1:0];
                    s_d.bus_en = HWDATA[epc_pkg::CTRL_BUS_EN];
                    s_d.dbg_en = HWDATA[epc_pkg::CTRL_DBG_EN];
                    set[epc_pkg::POS_NMI] = HWDATA[epc_pkg::CTRL_NMI_SET];
                    set[epc_pkg::POS_PSV] = HWDATA[epc_pkg::CTRL_PSV_SET];
                    clr[epc_pkg::POS_PSV] = HWDATA[epc_pkg::CTRL_PSV_CLR];
                end
                epc_pkg::REG_IRQ_EN: s_d.en = HWDATA & epc_pkg::IRQ_IMPL;
                epc_pkg::REG_IRQ_PEND: clr[47:16] = HWDATA;
                epc_pkg::REG_SYS_PRI:
                begin
                    for (int k = 0; k < 7; k++)
                        s_d.sys_pri[k] = HWDATA[3*k +: 3];
                end
                8'h14, 8'h18, 8'h1C, epc_pkg::REG_IRQ_PRI3:
                begin
                    for (int j = 0; j < 8; j++)
                    begin
                        if (epc_pkg::IRQ_IMPL[8*m + j])
                            s_d.irq_pri[8*m + j] = HWDATA[4*j +: 3];
                    end
                end
                default: ;
            endcase
        end

        // synchronous faults escalate when they cannot preempt
        if (MEM_FAULT)
            set[(pre[epc_pkg::POS_MEM] < s_q.act_rank) ? epc_pkg::POS_MEM : epc_pkg::POS_HARD] = 1'b1;
        if (BUS_FAULT_PRECISE)
            set[(s_q.bus_en && pre[epc_pkg::POS_BUS] < s_q.act_rank) ?
                epc_pkg::POS_BUS : epc_pkg::POS_HARD] = 1'b1;
        if (s_q.imp_s2 && !s_q.imp_s3)
            set[s_q.bus_en ? epc_pkg::POS_BUS : epc_pkg::POS_HARD] = 1'b1;
        if (USAGE_FAULT)
            set[(pre[epc_pkg::POS_USAGE] < s_q.act_rank) ? epc_pkg::POS_USAGE : epc_pkg::POS_HARD] = 1'b1;
        if (SVC_CALL)
            set[(pre[epc_pkg::POS_SVC] < s_q.act_rank) ? epc_pkg::POS_SVC : epc_pkg::POS_HARD] = 1'b1;
        if (DEBUG_MON_REQ && s_q.dbg_en && pre[epc_pkg::POS_DBG] < s_q.act_rank)
            set[epc_pkg::POS_DBG] = 1'b1;
        if (TICK_EXPIRE)
            set[epc_pkg::POS_TICK] = 1'b1;
        set[47:16] = set[47:16] | (s_q.irq_s2 & epc_pkg::IRQ_IMPL);

        // entry, return and chaining sequencer
        case (s_q.st)
            epc_pkg::ST_LOAD_SP:
            begin
                s_d.st = epc_pkg::ST_FETCH_RST;
                s_d.vec_addr = epc_pkg::VEC_RST;
            end
            epc_pkg::ST_FETCH_RST:
            begin
                s_d.st = epc_pkg::ST_THREAD;
                s_d.act_rank = epc_pkg::RANK_BASE;
            end
            epc_pkg::ST_THREAD, epc_pkg::ST_HANDLER:
            begin
                if (s_q.st == epc_pkg::ST_HANDLER && EXC_RETURN)
                begin
                    if (any && w_pre < top.rank)
                    begin
                        // chain straight into the next handler
                        s_d.act_pos = w_idx;
                        s_d.act_rank = w_pre;
                        clr[w_idx] = 1'b1;
                        s_d.vec_addr = {w_idx, 2'b00};
                        s_d.st = epc_pkg::ST_CHAIN;
                        s_d.cnt = epc_pkg::CHAIN_CYC - 4'h1;
                        s_d.chain = 1'b1;
                    end
                    else
                    begin
                        s_d.dep = s_q.dep - 4'h1;
                        s_d.act_pos = top.pos;
                        s_d.act_rank = top.rank;
                        s_d.st = epc_pkg::ST_UNSTACK;
                        s_d.cnt = epc_pkg::STACK_CYC - 4'h1;
                    end
                end
                else if (take)
                begin
                    s_d.stk[s_q.dep] = '{pos: s_q.act_pos, rank: s_q.act_rank};
                    s_d.dep = s_q.dep + 4'h1;
                    s_d.act_pos = w_idx;
                    s_d.act_rank = w_pre;
                    clr[w_idx] = 1'b1;
                    s_d.vec_addr = {w_idx, 2'b00};
                    s_d.st = epc_pkg::ST_STACK;
                    s_d.cnt = epc_pkg::STACK_CYC - 4'h1;
                end
            end
            epc_pkg::ST_STACK, epc_pkg::ST_CHAIN:
            begin
                if (s_q.cnt == 4'h0)
                    s_d.st = epc_pkg::ST_HANDLER;
                else
                    s_d.cnt = s_q.cnt - 4'h1;
            end
            epc_pkg::ST_UNSTACK:
            begin
                if (s_q.cnt == 4'h0)
                    s_d.st = (s_q.dep == 4'h0) ? epc_pkg::ST_THREAD : epc_pkg::ST_HANDLER;
                else
                    s_d.cnt = s_q.cnt - 4'h1;
            end
            default: s_d.st = epc_pkg::ST_THREAD;
        endcase

        // a set in the same cycle as a clear wins
        s_d.pend = (s_q.pend & ~clr) | set;

        // registered outputs follow the next state
        s_d.load_sp = s_d.st == epc_pkg::ST_LOAD_SP;
        s_d.push = s_d.st == epc_pkg::ST_STACK;
        s_d.pop = s_d.st == epc_pkg::ST_UNSTACK;
        s_d.vec_fetch = s_d.st == epc_pkg::ST_STACK || s_d.st == epc_pkg::ST_CHAIN ||
                        s_d.st == epc_pkg::ST_FETCH_RST;
        s_d.hmode = s_d.st == epc_pkg::ST_HANDLER || s_d.st == epc_pkg::ST_CHAIN ||
                    s_d.st == epc_pkg::ST_UNSTACK;
    end

    // -------------------------------------------------------------
    // state register
    // -------------------------------------------------------------

    // synchronous reset; all priority fields come up zero
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
            s_q <= epc_pkg::STATE_RST;
        else
            s_q <= s_d;
    end

    assign HRDATA = s_q.hrdata;
    assign HREADYOUT = s_q.hreadyout;
    assign HRESP = s_q.hresp;
    assign LOAD_SP = s_q.load_sp;
    assign VEC_FETCH = s_q.vec_fetch;
    assign VEC_ADDR = s_q.vec_addr;
    assign STACK_PUSH = s_q.push;
    assign STACK_POP = s_q.pop;
    assign TAIL_CHAIN = s_q.chain;
    assign HANDLER_MODE = s_q.hmode;
    assign ACTIVE_NUM = s_q.act_pos;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    sequence s_boot;
        LOAD_SP && VEC_ADDR == 8'h00 ##1 VEC_FETCH && VEC_ADDR == 8'h04 && !LOAD_SP
        ##1 s_q.act_rank == 4'hF && !HANDLER_MODE && !VEC_FETCH;
    endsequence

    sequence s_chain;
        (VEC_FETCH && !STACK_POP && !STACK_PUSH)[*2] ##1 (HANDLER_MODE && !VEC_FETCH);
    endsequence

    property p_boot;
        $rose(RST_B) |-> s_boot;
    endproperty
    a_boot: assert property (p_boot) else $error("boot order wrong");

    property p_pri_zero;
        $rose(RST_B) |-> s_q.sys_pri == '0 && s_q.irq_pri == '0;
    endproperty
    a_pri_zero: assert property (p_pri_zero) else $error("priority not zero after reset");

    property p_stack;
        $rose(STACK_PUSH) |-> (STACK_PUSH && VEC_FETCH && !HANDLER_MODE)[*8] ##1 (HANDLER_MODE && !STACK_PUSH);
    endproperty
    a_stack: assert property (p_stack) else $error("stacking length wrong");

    property p_chain;
        TAIL_CHAIN |-> s_chain;
    endproperty
    a_chain: assert property (p_chain) else $error("tail chain restacked");

    property p_unstack_mode;
        $fell(STACK_POP) |-> HANDLER_MODE == (s_q.dep != 4'h0);
    endproperty
    a_unstack_mode: assert property (p_unstack_mode) else $error("mode wrong after return");

    property p_preempt;
        take |-> w_pre < s_q.act_rank ##1 (ACTIVE_NUM == $past(w_idx) && STACK_PUSH);
    endproperty
    a_preempt: assert property (p_preempt) else $error("preemption wrong");

    property p_tie;
        take && vld[4] && vld[5] && full[4] == full[5] |-> w_idx != 6'h05;
    endproperty
    a_tie: assert property (p_tie) else $error("tie broken wrong way");

    property p_irq_en;
        take && w_idx >= 6'h10 |-> s_q.en[5'(w_idx - 6'h10)] && epc_pkg::POS_IMPL[w_idx];
    endproperty
    a_irq_en: assert property (p_irq_en) else $error("disabled line taken");

    property p_escalate;
        MEM_FAULT && !(pre[4] < s_q.act_rank) |=> s_q.pend[3];
    endproperty
    a_escalate: assert property (p_escalate) else $error("fault not escalated");

    property p_nmi_sw;
        $rose(s_q.pend[2]) |-> $past(nmi_wr);
    endproperty
    a_nmi_sw: assert property (p_nmi_sw) else $error("nmi pended without write");

    property p_group;
        s_q.grp == 2'h3 |-> pre[4] == 4'h3 && pre[16] == 4'h3;
    endproperty
    a_group: assert property (p_group) else $error("grouping ignored");

endmodule

/* File: epc_top_test.sv */
// self-checking bench of the exception priority controller
`timescale 1ns/1ns
module epc_top_test;
    logic CLK = 1'b0, RST_B = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, SVC_CALL = 1'b0, DEBUG_MON_REQ = 1'b0;
    logic TICK_EXPIRE = 1'b0, MEM_FAULT = 1'b0, BUS_FAULT_PRECISE = 1'b0, BUS_FAULT_IMPRECISE = 1'b0;
    logic USAGE_FAULT = 1'b0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, IRQ_IN = 32'h0, HRDATA;
    logic [1:0] HTRANS = 2'h0;
    logic [2:0] HSIZE = 3'h2;
    logic [7:0] VEC_ADDR, dly_q = 8'h28;
    logic [5:0] ACTIVE_NUM;
    logic HREADY, HREADYOUT, HRESP, EXC_RETURN, LOAD_SP, VEC_FETCH, STACK_PUSH, STACK_POP, TAIL_CHAIN, HANDLER_MODE;
    int err_total = 0, total_checks = 0, cyc = 0;
    // clock, ready loop-back of the one slave, and the two parties
    always #5 CLK = ~CLK;
    assign HREADY = HREADYOUT;
    epc_top DUT (.CLK, .RST_B, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT,
        .HRESP, .IRQ_IN, .MEM_FAULT, .BUS_FAULT_PRECISE, .BUS_FAULT_IMPRECISE, .USAGE_FAULT, .SVC_CALL,
        .DEBUG_MON_REQ, .TICK_EXPIRE, .EXC_RETURN, .LOAD_SP, .VEC_FETCH, .VEC_ADDR, .STACK_PUSH, .STACK_POP,
        .TAIL_CHAIN, .HANDLER_MODE, .ACTIVE_NUM);
    epc_core_model core (.clk(CLK), .rst_b(RST_B), .hmode(HANDLER_MODE), .busy(VEC_FETCH | STACK_PUSH | STACK_POP),
        .dly(dly_q), .exc_ret(EXC_RETURN));
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // let one edge land
    task automatic step;
        @(posedge CLK);
        #1;
    endtask
    // single word transfer; read data is compared with d
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd_v;
        logic rdy_v;
        @(posedge CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        do @(posedge CLK); while (HREADY !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        // data phase values are taken while they stand, away from the launching edge
        do
        begin
            @(negedge CLK);
            rd_v = HRDATA;
            rdy_v = HREADY;
            @(posedge CLK);
        end
        while (rdy_v !== 1'b1);
        if (!w)
            chk(rd_v, d);
    endtask
    // first vector fetch cycle: active position and vector address
    task automatic fetch_of(input logic [5:0] pos);
        // let a fetch already under way finish before looking for the next one
        while (VEC_FETCH === 1'b1)
            step();
        do step(); while (VEC_FETCH !== 1'b1);
        chk({ACTIVE_NUM, VEC_ADDR}, {pos, pos, 2'b00});
    endtask
    task automatic t_reset;
        repeat (2) @(posedge CLK);
        RST_B <= 1'b1;
        #1;
        chk({LOAD_SP, VEC_ADDR}, 9'h100);
        step();
        chk({LOAD_SP, VEC_FETCH, VEC_ADDR}, 10'h104);
        step();
        chk({HANDLER_MODE, ACTIVE_NUM}, 7'h00);
        bus(1'b0, epc_pkg::REG_STATUS, 32'h000003C0);
        bus(1'b0, epc_pkg::REG_SYS_PRI, 32'h0);
        bus(1'b0, epc_pkg::REG_IRQ_PRI0, 32'h0);
        chk({HREADYOUT, HRESP}, 2'b10);
        bus(1'b1, epc_pkg::REG_CTRL, 32'h00000003);
        step();
        bus(1'b0, epc_pkg::REG_CTRL, 32'h00000003);
        bus(1'b1, epc_pkg::REG_CTRL, 32'h00000000);
    endtask
    task automatic t_tick;
        int n;
        n = 0;
        @(posedge CLK);
        dly_q <= 8'h02;
        TICK_EXPIRE <= 1'b1;
        @(posedge CLK);
        TICK_EXPIRE <= 1'b0;
        fetch_of(6'h0F);
        repeat (8) step();
        chk({HANDLER_MODE, STACK_PUSH}, 2'b10);
        do step(); while (STACK_POP !== 1'b1);
        do
        begin
            step();
            n++;
        end
        while (STACK_POP === 1'b1);
        chk(n, 8);
        chk({HANDLER_MODE, ACTIVE_NUM}, 7'h00);
    endtask
    task automatic t_chain;
        bus(1'b1, epc_pkg::REG_IRQ_EN, 32'h0000000B);
        bus(1'b0, epc_pkg::REG_IRQ_EN, 32'h00000003);
        @(posedge CLK);
        dly_q <= 8'h28;
        IRQ_IN <= 32'h0000000B;
        fetch_of(6'h10);
        @(posedge CLK);
        IRQ_IN <= 32'h00000002;
        bus(1'b1, epc_pkg::REG_IRQ_PEND, 32'h00000001);
        do step(); while (TAIL_CHAIN !== 1'b1);
        chk({STACK_PUSH, STACK_POP}, 2'b00);
        step();
        chk({VEC_FETCH, VEC_ADDR, ACTIVE_NUM}, {1'b1, 8'h44, 6'h11});
        @(posedge CLK);
        IRQ_IN <= 32'h0;
        bus(1'b1, epc_pkg::REG_IRQ_PEND, 32'h00000002);
        do step(); while (ACTIVE_NUM !== 6'h00);
    endtask
    task automatic t_nest;
        bus(1'b1, epc_pkg::REG_IRQ_PRI0, 32'h00000003);
        @(posedge CLK);
        IRQ_IN <= 32'h00000001;
        fetch_of(6'h10);
        @(posedge CLK);
        IRQ_IN <= 32'h0;
        bus(1'b1, epc_pkg::REG_IRQ_PEND, 32'h00000001);
        do step(); while (HANDLER_MODE !== 1'b1);
        @(posedge CLK);
        SVC_CALL <= 1'b1;
        @(posedge CLK);
        SVC_CALL <= 1'b0;
        fetch_of(6'h0B);
        bus(1'b1, epc_pkg::REG_CTRL, 32'h00000100);
        fetch_of(6'h02);
        do step(); while ((ACTIVE_NUM !== 6'h0B) || (HANDLER_MODE !== 1'b1) || (STACK_POP !== 1'b0));
        @(posedge CLK);
        TICK_EXPIRE <= 1'b1;
        @(posedge CLK);
        TICK_EXPIRE <= 1'b0;
        repeat (6) step();
        chk(ACTIVE_NUM, 6'h0B);
        do step(); while (TAIL_CHAIN !== 1'b1);
        step();
        chk(ACTIVE_NUM, 6'h0F);
        do step(); while (ACTIVE_NUM !== 6'h00);
        @(posedge CLK);
        DEBUG_MON_REQ <= 1'b1;
        @(posedge CLK);
        DEBUG_MON_REQ <= 1'b0;
        repeat (6) step();
        chk({VEC_FETCH, ACTIVE_NUM}, 7'h00);
        do step(); while ((HANDLER_MODE !== 1'b0) || (STACK_POP !== 1'b0));
        bus(1'b1, epc_pkg::REG_CTRL, 32'h00000010);
        @(posedge CLK);
        DEBUG_MON_REQ <= 1'b1;
        @(posedge CLK);
        DEBUG_MON_REQ <= 1'b0;
        fetch_of(6'h0C);
        do step(); while (ACTIVE_NUM !== 6'h00);
    endtask
    // verdict and end of run
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // hang guard
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            tally_and_finish();
        end
    end
    // main sequence
    initial
    begin
        t_reset();
        t_tick();
        t_chain();
        t_nest();
        tally_and_finish();
    end
endmodule
